//--- tb/cfchk_checker_test.sv
`timescale 1ns/1ps
module cfchk_checker_test;
    import cfchk_pkg::*;
    logic clk = 1'h0, rst_b = 1'h0, uen = 1'h1, sen = 1'h1, ibt = 1'h1, priv = 1'h1;
    logic st = 1'h0, st_sh = 1'h0, st_pg = 1'h0;
    logic [2:0] op = 3'h0;
    logic [CFCHK_ADDR_W-1:0] ra = '0, dra = '0;
    logic rt, cl, he, rr, ind, m32, m64, flt, blk, aw, ovf;
    logic [1:0] cause;
    int n_mismatch = 0, total_checks = 0;
    // Core clock
    always #50 clk = ~clk;
    cfchk_pipe_model pipe (.op_i(op), .retire_o(rt), .call_o(cl), .handler_o(he),
        .ret_o(rr), .ind_o(ind), .m32_o(m32), .m64_o(m64));
    cfchk_checker dut (.clock_i(clk), .rst_b_i(rst_b), .ss_en_user_i(uen),
        .ss_en_super_i(sen), .ibt_en_i(ibt), .priv_i(priv), .retire_i(rt),
        .call_i(cl), .handler_entry_i(he), .return_instr_i(rr), .indirect_i(ind),
        .landing_marker_32bit_i(m32), .landing_marker_64bit_i(m64), .ret_addr_i(ra),
        .data_ret_addr_i(dra), .store_i(st), .store_shadow_i(st_sh),
        .store_page_ss_i(st_pg), .control_protection_fault_o(flt),
        .fault_cause_o(cause), .store_block_o(blk), .await_landing_o(aw),
        .ss_overflow_o(ovf));
    task automatic chk1(input logic got, input logic exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: flag %b not %b", $time, got, exp);
        end
    endtask
    task automatic chk2(input logic [1:0] got, input logic [1:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: cause %h not %h", $time, got, exp);
        end
    endtask
    // One retire, outputs settled at the following falling edge
    task automatic step(input logic [2:0] o, input logic [63:0] a, input logic [63:0] d);
        op = o;
        ra = a;
        dra = d;
        @(negedge clk);
    endtask
    // One cycle with no retire and no store check
    task automatic idle();
        op = 3'h0;
        st = 1'h0;
        @(negedge clk);
    endtask
    task automatic t_branch();
        for (int m = 5; m <= 6; m++) begin
            step(3'h4, '0, '0);
            chk1(aw, 1'h1);
            step(3'(m), '0, '0);
            chk1(aw, 1'h0);
            chk1(flt, 1'h0);
        end
        step(3'h4, '0, '0);
        step(3'h7, '0, '0);
        chk1(flt, 1'h1);
        chk2(cause, CFCHK_CAUSE_BRANCH);
        chk1(aw, 1'h0);
        // Marker with nothing pending changes nothing
        step(3'h5, '0, '0);
        chk1(aw, 1'h0);
        chk1(flt, 1'h0);
        // Indirect after indirect faults and re-arms
        step(3'h4, '0, '0);
        step(3'h4, '0, '0);
        chk1(flt, 1'h1);
        chk1(aw, 1'h1);
        // Dropping the enable returns the tracker to idle
        ibt = 1'h0;
        step(3'h7, '0, '0);
        chk1(aw, 1'h0);
        chk1(flt, 1'h0);
        step(3'h4, '0, '0);
        chk1(aw, 1'h0);
        ibt = 1'h1;
        idle();
    endtask
    task automatic t_stack();
        step(3'h1, 64'hA5, '0);
        step(3'h2, 64'h5A, '0);
        step(3'h3, '0, 64'h5A);
        chk1(flt, 1'h0);
        chk2(cause, CFCHK_CAUSE_NONE);
        step(3'h3, '0, 64'hA4);
        chk1(flt, 1'h1);
        chk2(cause, CFCHK_CAUSE_RET);
        uen = 1'h0;
        step(3'h3, '0, 64'h1);
        chk1(flt, 1'h0);
        // Supervisor follows its own enable
        priv = CFCHK_PRIV_SUPER;
        step(3'h3, '0, 64'h1);
        chk1(flt, 1'h1);
        sen = 1'h0;
        uen = 1'h1;
        step(3'h3, '0, 64'h1);
        chk1(flt, 1'h0);
        sen = 1'h1;
        priv = CFCHK_PRIV_USER;
        idle();
    endtask
    // Fill the stack, overflow once, then unwind it in order
    task automatic t_depth();
        for (int i = 0; i < CFCHK_DEPTH; i++) begin
            step(3'h1, 64'h10 + 64'(i), '0);
            chk1(ovf, 1'h0);
        end
        step(3'h1, 64'hFF, '0);
        chk1(ovf, 1'h1);
        chk1(flt, 1'h0);
        for (int i = CFCHK_DEPTH - 1; i >= 0; i--) begin
            step(3'h3, '0, 64'h10 + 64'(i));
            chk1(flt, 1'h0);
        end
        step(3'h3, '0, 64'h10);
        chk1(flt, 1'h1);
        chk2(cause, CFCHK_CAUSE_RET);
        idle();
    endtask
    task automatic t_store(input logic sh, input logic pg, input logic exp);
        st = 1'h1;
        st_sh = sh;
        st_pg = pg;
        @(negedge clk);
        chk1(blk, exp);
        chk1(flt, exp);
        chk2(cause, exp ? CFCHK_CAUSE_STORE : CFCHK_CAUSE_NONE);
    endtask
    // Reset in mid-run clears the tracker and the stack pointer
    task automatic t_reset();
        step(3'h1, 64'h33, '0);
        step(3'h4, '0, '0);
        chk1(aw, 1'h1);
        rst_b = 1'h0;
        op = 3'h0;
        @(negedge clk);
        chk1(aw, 1'h0);
        chk1(flt, 1'h0);
        rst_b = 1'h1;
        @(negedge clk);
        chk1(aw, 1'h0);
        step(3'h3, '0, 64'h33);
        chk1(flt, 1'h1);
        idle();
    endtask
    task automatic close_out();
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // Watchdog
    initial begin
        #200000;
        n_mismatch++;
        close_out();
    end
    initial begin
        repeat (4) @(negedge clk);
        rst_b = 1'h1;
        @(negedge clk);
        chk1(aw, 1'h0);
        chk1(flt, 1'h0);
        t_branch();
        t_stack();
        t_depth();
        t_store(1'h0, 1'h1, 1'h1);
        t_store(1'h1, 1'h1, 1'h0);
        t_store(1'h1, 1'h0, 1'h1);
        t_store(1'h0, 1'h0, 1'h0);
        idle();
        t_reset();
        close_out();
    end
endmodule

//--- tb/cfchk_pipe_model.sv
`timescale 1ns/1ps
// Retire stage stand-in: any opcode but 0 raises the retire strobe plus at most one other event strobe
module cfchk_pipe_model (
    // Opcode from bench
    input wire logic [2:0] op_i,
    // Event strobes
    output logic retire_o,
    output logic call_o,
    output logic handler_o,
    output logic ret_o,
    output logic ind_o,
    output logic m32_o,
    output logic m64_o
);
    // Opcode 0 is a bubble, 7 an ordinary instruction
    assign retire_o = (op_i != 3'h0);
    assign call_o = (op_i == 3'h1);
    assign handler_o = (op_i == 3'h2);
    assign ret_o = (op_i == 3'h3);
    assign ind_o = (op_i == 3'h4);
    assign m32_o = (op_i == 3'h5);
    assign m64_o = (op_i == 3'h6);
endmodule

//--- verilog/cfchk_checker.sv
`timescale 1ns/1ps
// Behaviour
// (RL1) Shadow stack separate, per-privilege enables
// (RL2) Shadow page attribute protects stack contents
// (RL3) Push return address on calls, handler entries
// (RL4) Return compares both addresses, mismatch faults
// (RL5) Ordinary stores to shadow pages blocked
// (RL6) Both landing markers valid, otherwise no-ops
// (RL7) Indirect branch enters await-landing state
// (RL8) Non-marker after indirect branch faults
// (RL9) Marker after indirect branch returns idle
// (RL10) Reset idle; no return fault before return
module cfchk_checker #(
    parameter int unsigned ADDR_W = cfchk_pkg::CFCHK_ADDR_W,
    parameter int unsigned DEPTH = cfchk_pkg::CFCHK_DEPTH
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic rst_b_i,
    // Enables
    input wire logic ss_en_user_i,
    input wire logic ss_en_super_i,
    input wire logic ibt_en_i,
    input wire logic priv_i,
    // Retire events
    input wire logic retire_i,
    input wire logic call_i,
    input wire logic handler_entry_i,
    input wire logic return_instr_i,
    input wire logic indirect_i,
    input wire logic landing_marker_32bit_i,
    input wire logic landing_marker_64bit_i,
    input wire logic [ADDR_W-1:0] ret_addr_i,
    input wire logic [ADDR_W-1:0] data_ret_addr_i,
    // Store checks
    input wire logic store_i,
    input wire logic store_shadow_i,
    input wire logic store_page_ss_i,
    // Fault outputs
    output logic control_protection_fault_o,
    output logic [1:0] fault_cause_o,
    output logic store_block_o,
    output logic await_landing_o,
    output logic ss_overflow_o
);
    import cfchk_pkg::*;

    localparam int unsigned PTR_W = $clog2(DEPTH + 1);
    localparam logic [PTR_W-1:0] PTR_ONE = PTR_W'(1);
    localparam logic [PTR_W-1:0] PTR_MAX = PTR_W'(DEPTH);

    ////////////////////////////////////////////////////////////////////////
    // Decode
    // Pointer is one bit wider than the index so that full and empty differ
    logic [ADDR_W-1:0] ss_mem_q [DEPTH];
    logic [PTR_W-1:0] sp_q;
    logic [PTR_W-1:0] sp_d;
    cfchk_trk_t trk_q;
    cfchk_trk_t trk_d;

    // Privilege picks which enable governs the shadow stack
    wire ss_active = (priv_i == CFCHK_PRIV_USER) ? ss_en_user_i : ss_en_super_i; // RL1
    // Either marker width ends a pending indirect transfer
    wire landing_marker_instr = landing_marker_32bit_i | landing_marker_64bit_i; // RL6

    // Calls and handler entries push, returns pop
    wire do_push = retire_i & ss_active & (call_i | handler_entry_i); // RL3
    wire do_pop = retire_i & ss_active & return_instr_i;
    wire full = (sp_q == PTR_MAX);
    wire empty = (sp_q == '0);

    // Top entry reads as zero when empty; an empty pop always faults
    wire [PTR_W-1:0] top_idx = sp_q - PTR_ONE;
    wire [ADDR_W-1:0] ss_top = empty ? '0 : ss_mem_q[top_idx[$clog2(DEPTH)-1:0]];
    wire ret_mismatch = do_pop & (empty | (ss_top != data_ret_addr_i)); // RL4
    // A push on a full stack is dropped and reported, not faulted
    wire push_ok = do_push & ~full;

    // Shadow stores only to shadow pages, ordinary stores never
    wire store_bad = store_i & (store_page_ss_i ^ store_shadow_i); // RL2 RL5

    // Any retire other than a marker breaks a pending indirect transfer
    wire trk_busy = ibt_en_i & (trk_q == CFCHK_AWAIT_LANDING);
    wire branch_bad = retire_i & trk_busy & ~landing_marker_instr; // RL8

    // Cause priority: return, then branch, then store
    wire [1:0] cause_d = ret_mismatch ? CFCHK_CAUSE_RET :
                         branch_bad ? CFCHK_CAUSE_BRANCH :
                         store_bad ? CFCHK_CAUSE_STORE : CFCHK_CAUSE_NONE;

    // Stack pointer next value
    always_comb begin
        sp_d = sp_q;
        if (push_ok) begin
            sp_d = sp_q + PTR_ONE;
        end else if (do_pop && !empty) begin
            sp_d = top_idx;
        end
    end

    // Tracker next state
    always_comb begin
        trk_d = trk_q;
        case (trk_q)
            CFCHK_IDLE: begin
                if (retire_i && ibt_en_i && indirect_i) begin
                    trk_d = CFCHK_AWAIT_LANDING; // RL7
                end
            end
            CFCHK_AWAIT_LANDING: begin
                if (!ibt_en_i) begin
                    trk_d = CFCHK_IDLE;
                end else if (retire_i && landing_marker_instr) begin
                    trk_d = CFCHK_IDLE; // RL9
                end else if (retire_i) begin
                    trk_d = indirect_i ? CFCHK_AWAIT_LANDING : CFCHK_IDLE;
                end
            end
            default: trk_d = CFCHK_IDLE;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Shadow stack storage
    // Entries are not reset; only the pointer is, so stale data is never read
    genvar gi;
    generate
        for (gi = 0; gi < DEPTH; gi++) begin : g_ss
            always_ff @(posedge clock_i) begin
                if (push_ok && sp_q == PTR_W'(gi)) begin
                    ss_mem_q[gi] <= ret_addr_i; // RL3
                end
            end
        end
    endgenerate

    // State registers
    // Fault pulses stand one cycle, the waiting flag until it is cleared
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sp_q <= '0;
            trk_q <= CFCHK_IDLE; // RL10
            control_protection_fault_o <= 1'h0; // RL10
            fault_cause_o <= CFCHK_CAUSE_NONE;
            store_block_o <= 1'h0;
            await_landing_o <= 1'h0;
            ss_overflow_o <= 1'h0;
        end else begin
            sp_q <= sp_d;
            trk_q <= trk_d;
            control_protection_fault_o <= ret_mismatch | branch_bad | store_bad; // RL4 RL8
            fault_cause_o <= cause_d;
            store_block_o <= store_bad; // RL5
            await_landing_o <= (trk_d == CFCHK_AWAIT_LANDING);
            ss_overflow_o <= do_push & full;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    a_ret_mismatch_fault: assert property (@(posedge clock_i) disable iff (!rst_b_i) // RL4
        ret_mismatch |=> control_protection_fault_o && fault_cause_o == CFCHK_CAUSE_RET)
        else $error("return mismatch not faulted");
    a_branch_enters_wait: assert property (@(posedge clock_i) disable iff (!rst_b_i) // RL7
        (retire_i && ibt_en_i && indirect_i && trk_q == CFCHK_IDLE)
        |=> await_landing_o && trk_q == CFCHK_AWAIT_LANDING)
        else $error("indirect branch did not arm tracker");
    a_missing_marker_fault: assert property (@(posedge clock_i) disable iff (!rst_b_i) // RL8
        (retire_i && ibt_en_i && trk_q == CFCHK_AWAIT_LANDING && !landing_marker_32bit_i
         && !landing_marker_64bit_i) |=> control_protection_fault_o)
        else $error("missing landing marker not faulted");
    a_marker_to_idle: assert property (@(posedge clock_i) disable iff (!rst_b_i) // RL9
        (retire_i && ibt_en_i && trk_q == CFCHK_AWAIT_LANDING
         && (landing_marker_32bit_i || landing_marker_64bit_i))
        |=> trk_q == CFCHK_IDLE && fault_cause_o != CFCHK_CAUSE_BRANCH)
        else $error("landing marker did not clear tracker");
    a_store_blocked: assert property (@(posedge clock_i) disable iff (!rst_b_i) // RL5
        (store_i && store_page_ss_i && !store_shadow_i) |=> store_block_o)
        else $error("store to shadow page not blocked");
    a_push_grows: assert property (@(posedge clock_i) disable iff (!rst_b_i) // RL3
        (do_push && !full && !do_pop) |=> sp_q == $past(sp_q) + PTR_ONE)
        else $error("call did not push");
    a_disabled_no_push: assert property (@(posedge clock_i) disable iff (!rst_b_i) // RL1
        (!ss_active) |=> sp_q == $past(sp_q))
        else $error("shadow stack moved while disabled");
    a_no_spurious_fault: assert property (@(posedge clock_i) disable iff (!rst_b_i) // RL10
        (!do_pop && !branch_bad && !store_bad) |=> !control_protection_fault_o)
        else $error("fault without cause");
    // Full stack drops the push and keeps its pointer
    a_overflow_drops_push: assert property (@(posedge clock_i) disable iff (!rst_b_i) // RL3
        (do_push && full && !do_pop) |=> ss_overflow_o && sp_q == $past(sp_q))
        else $error("push on full stack not dropped");
    // A pop on a non-empty stack takes one entry off
    a_pop_shrinks: assert property (@(posedge clock_i) disable iff (!rst_b_i) // RL4
        (do_pop && !empty && !push_ok) |=> sp_q == $past(sp_q) - PTR_ONE)
        else $error("return did not pop");
    // A pop on an empty stack has nothing to match and faults
    a_empty_pop_fault: assert property (@(posedge clock_i) disable iff (!rst_b_i) // RL4
        (do_pop && empty) |=> control_protection_fault_o && fault_cause_o == CFCHK_CAUSE_RET)
        else $error("empty pop not faulted");
    // Tracking disabled keeps the tracker idle
    a_tracking_off_idle: assert property (@(posedge clock_i) disable iff (!rst_b_i) // RL7
        (!ibt_en_i) |=> trk_q == CFCHK_IDLE && !await_landing_o)
        else $error("tracker busy while disabled");
    // A refused store reports the store cause when nothing outranks it
    a_store_fault_cause: assert property (@(posedge clock_i) disable iff (!rst_b_i) // RL5
        (store_bad && !ret_mismatch && !branch_bad)
        |=> control_protection_fault_o && fault_cause_o == CFCHK_CAUSE_STORE)
        else $error("refused store without store cause");
    // The stack's own stores to its pages pass
    a_shadow_store_passes: assert property (@(posedge clock_i) disable iff (!rst_b_i) // RL2
        (store_i && store_page_ss_i && store_shadow_i) |=> !store_block_o)
        else $error("shadow store to shadow page blocked");
    // A marker with nothing pending has no effect
    a_idle_marker_inert: assert property (@(posedge clock_i) disable iff (!rst_b_i) // RL6
        (retire_i && trk_q == CFCHK_IDLE && landing_marker_instr && !call_i
         && !handler_entry_i && !return_instr_i && !indirect_i && !store_bad)
        |=> sp_q == $past(sp_q) && !await_landing_o && !control_protection_fault_o)
        else $error("idle landing marker changed state");
endmodule

//--- verilog/cfchk_pkg.sv
package cfchk_pkg;
    // Widths
    localparam int unsigned CFCHK_ADDR_W = 64;
    localparam int unsigned CFCHK_DEPTH = 16;
    // Privilege encodings
    localparam logic CFCHK_PRIV_USER = 1'h1;
    localparam logic CFCHK_PRIV_SUPER = 1'h0;
    // Fault cause codes
    localparam logic [1:0] CFCHK_CAUSE_NONE = 2'h0;
    localparam logic [1:0] CFCHK_CAUSE_RET = 2'h1;
    localparam logic [1:0] CFCHK_CAUSE_BRANCH = 2'h2;
    localparam logic [1:0] CFCHK_CAUSE_STORE = 2'h3;
    // Tracker states
    typedef enum logic {
        CFCHK_IDLE,
        CFCHK_AWAIT_LANDING
    } cfchk_trk_t;
endpackage
